// file: fac_device_end.sv
`default_nettype none
`include "fac_params.svh"
// Behaviour
// - drive bus init on unrecoverable condition
// - bus init resets lock and arbiter
// - in-order queue survives bus init
// - re-arbitrate then finish pending entries
// - observation off: central agent decides
// - busy agent asserts block next request
// - owner issues nothing during stall
// - platform select low halts device
// - drive six-bit breakpoint monitor
// - bit four is probe ready
// - debug tools drive bit five request
// - priority request stops non-locked requests
// - priority agent holds until done
// - request bus on request zero
// - agent id set to constant FAC_AGENT_ID0
// - drive clock frequency select
module fac_device_end #(
  parameter int QUEUE_W = `FAC_QUEUE_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  fac_bus_if.dev                bus,
  input  wire logic             platform_select_i,
  input  wire logic             bus_init_error_drive_en_i,
  input  wire logic             bus_init_error_obs_en_i,
  input  wire logic             fatal_err_i,
  input  wire logic             busy_i,
  input  wire logic             txn_req_i,
  input  wire logic             txn_locked_i,
  input  wire logic             txn_done_i,
  input  wire logic             probe_ready_i,
  input  wire logic [3:0]       bp_status_i,
  input  wire logic             probe_req_pin_i,
  input  wire logic [`FAC_BSEL_W-1:0] freq_sel_i,
  output logic                  txn_issue_o,
  output logic                  probe_req_o,
  output logic                  bus_init_error_seen_o,
  output logic                  agent_id_o,
  output logic [QUEUE_W-1:0]    pending_o,
  output logic                  operational_o
);
  import fac_pkg::*;
  initial begin
    if (QUEUE_W < 1 || QUEUE_W > 16) $error("QUEUE_W out of range");
  end
  typedef struct packed {
    fac_arb_t               arb;
    logic                   lock;
    logic [QUEUE_W-1:0]     pend;
    logic                   cfg_done;
    logic                   drv_en;
    logic                   obs_en;
    logic                   id;
    logic [1:0]             ps_s;
    logic [1:0]             bi_s;
    logic [1:0]             bnr_s;
    logic [1:0]             priority_bus_request_s;
    logic [1:0]             probe_request_s;
    logic                   bus_init_error_drv;
    logic                   bnr_drv;
    logic                   issue;
    logic                   seen;
    logic [`FAC_BPM_W-1:0]  bpm;
    logic [`FAC_BSEL_W-1:0] bsel;
  } fac_dev_t;
  fac_dev_t s_r, s_nxt;
  logic op, bus_init_error_in, stall, prio;
  assign op       = s_r.ps_s[1];
  assign bus_init_error_in = !s_r.bi_s[1];
  assign stall    = !s_r.bnr_s[1];
  assign prio     = !s_r.priority_bus_request_s[1];
  always_comb begin
    s_nxt        = s_r;
    s_nxt.ps_s   = {s_r.ps_s[0], platform_select_i};
    s_nxt.bi_s   = {s_r.bi_s[0], bus.bus_init_error_n};
    s_nxt.bnr_s  = {s_r.bnr_s[0], bus.block_next_request_n};
    s_nxt.priority_bus_request_s = {s_r.priority_bus_request_s[0], bus.priority_bus_request_n};
    s_nxt.probe_request_s = {s_r.probe_request_s[0], probe_req_pin_i};
    s_nxt.issue  = 1'b0;
    // power-on straps caught on first clock after reset release
    if (!s_r.cfg_done) begin
      s_nxt.cfg_done = 1'b1;
      s_nxt.drv_en   = bus_init_error_drive_en_i;
      s_nxt.obs_en   = bus_init_error_obs_en_i;
      s_nxt.id       = `FAC_AGENT_ID0;
      s_nxt.bsel     = freq_sel_i;
    end
    s_nxt.bus_init_error_drv = op && s_r.drv_en && fatal_err_i;
    s_nxt.bnr_drv   = op && busy_i;
    s_nxt.bpm = {1'b1, !probe_ready_i, ~bp_status_i};
    if (txn_req_i && op && s_r.pend != '1) begin
      s_nxt.pend = s_r.pend + 1'b1;
    end
    if (txn_done_i && s_r.pend != '0) begin
      s_nxt.pend = s_nxt.pend - 1'b1;
    end
    // a locked sequence may still be waiting for ownership when priority arrives
    if (txn_locked_i && s_r.arb != FAC_ARB_IDLE) begin
      s_nxt.lock = 1'b1;
    end else if (!txn_locked_i) begin
      s_nxt.lock = 1'b0;
    end
    unique case (s_r.arb)
      FAC_ARB_IDLE: begin
        if (op && s_r.pend != '0) begin
          s_nxt.arb = FAC_ARB_REQ;
        end
      end
      FAC_ARB_REQ: begin
        if (!prio || s_r.lock) begin
          s_nxt.arb = FAC_ARB_OWN;
        end
      end
      FAC_ARB_OWN: begin
        if (!stall && (!prio || s_r.lock) && s_r.pend != '0) begin
          s_nxt.issue = 1'b1;
        end
        if (s_r.pend == '0) begin
          s_nxt.arb = FAC_ARB_IDLE;
        end
      end
    endcase
    s_nxt.seen = bus_init_error_in;
    // queue counter deliberately untouched here
    if (bus_init_error_in && s_r.obs_en) begin
      s_nxt.arb  = FAC_ARB_IDLE;
      s_nxt.lock = 1'b0;
      s_nxt.issue = 1'b0;
    end
    if (!op) begin
      s_nxt.arb   = FAC_ARB_IDLE;
      s_nxt.issue = 1'b0;
    end
    if (rst_i) begin
      s_nxt = '0;
      s_nxt.ps_s = 2'h3;
      s_nxt.bi_s = 2'h3;
      s_nxt.bnr_s = 2'h3;
      s_nxt.priority_bus_request_s = 2'h3;
      s_nxt.probe_request_s = 2'h3;
      s_nxt.bpm = '1;
      s_nxt.bsel = `FAC_BSEL_RST;
    end
  end
  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end
  assign bus.bus_request_zero_n   = !(s_r.arb != FAC_ARB_IDLE);
  assign bus.breakpoint_monitor_n = s_r.bpm;
  assign bus.clock_freq_select    = s_r.bsel;
  assign bus.dev_bus_init_error_oe         = s_r.bus_init_error_drv;
  assign bus.dev_bnr_oe           = s_r.bnr_drv;
  assign txn_issue_o   = s_r.issue;
  assign probe_req_o   = !s_r.probe_request_s[1];
  assign bus_init_error_seen_o  = s_r.seen;
  assign agent_id_o    = s_r.id;
  assign pending_o     = s_r.pend;
  assign operational_o = op;
endmodule
`default_nettype wire

// file: fac_params.svh
`ifndef FAC_PARAMS_SVH
`define FAC_PARAMS_SVH
`define FAC_BPM_W       6
`define FAC_BPM_PROBE_READY    4
`define FAC_BPM_PROBE_REQUEST    5
`define FAC_BSEL_W      2
`define FAC_BSEL_RST    2'h1
`define FAC_AGENT_ID0   1'h0
`define FAC_QUEUE_W     4
`endif

// file: fac_pkg.sv
`default_nettype none
package fac_pkg;
  typedef enum logic [1:0] {
    FAC_ARB_IDLE,
    FAC_ARB_REQ,
    FAC_ARB_OWN
  } fac_arb_t;
endpackage
`default_nettype wire

// file: fac_bus_if.sv
`default_nettype none
`include "fac_params.svh"
interface fac_bus_if;
  logic                    bus_init_error_n;
  logic                    block_next_request_n;
  logic                    priority_bus_request_n;
  logic                    bus_request_zero_n;
  logic [`FAC_BPM_W-1:0]   breakpoint_monitor_n;
  logic [`FAC_BSEL_W-1:0]  clock_freq_select;
  logic                    dev_bus_init_error_oe;
  logic                    dev_bnr_oe;
  logic                    cen_bus_init_error_oe;
  logic                    cen_bnr_oe;
  assign bus_init_error_n     = !(dev_bus_init_error_oe || cen_bus_init_error_oe);
  assign block_next_request_n = !(dev_bnr_oe || cen_bnr_oe);
  modport dev (
    input  bus_init_error_n, block_next_request_n, priority_bus_request_n,
    output bus_request_zero_n, breakpoint_monitor_n, clock_freq_select,
           dev_bus_init_error_oe, dev_bnr_oe
  );
  modport cen (
    input  bus_init_error_n, block_next_request_n, bus_request_zero_n,
           breakpoint_monitor_n, clock_freq_select,
    output priority_bus_request_n, cen_bus_init_error_oe, cen_bnr_oe
  );
endinterface
`default_nettype wire

// file: fac_central_end.sv
`default_nettype none
`include "fac_params.svh"
module fac_central_end (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  fac_bus_if.cen                bus,
  input  wire logic             prio_want_i,
  input  wire logic             prio_done_i,
  input  wire logic             bus_init_error_drive_i,
  input  wire logic             stall_i,
  input  wire logic             probe_req_i,
  output logic                  probe_ready_o,
  output logic                  agent_req_o,
  output logic                  bus_init_error_seen_o,
  output logic [`FAC_BSEL_W-1:0] freq_sel_o
);
  import fac_pkg::*;
  typedef struct packed {
    logic                   prio;
    logic [1:0]             bnr_s;
    logic [1:0]             br_s;
    logic [1:0]             rdy_s;
    logic [1:0]             bi_s;
    logic                   ready;
    logic                   req;
    logic                   seen;
    logic [`FAC_BSEL_W-1:0] fsel;
  } fac_cen_t;
  fac_cen_t s_r, s_nxt;
  always_comb begin
    s_nxt       = s_r;
    s_nxt.bnr_s = {s_r.bnr_s[0], bus.block_next_request_n};
    s_nxt.br_s  = {s_r.br_s[0], bus.bus_request_zero_n};
    s_nxt.rdy_s = {s_r.rdy_s[0], bus.breakpoint_monitor_n[`FAC_BPM_PROBE_READY]};
    s_nxt.bi_s  = {s_r.bi_s[0], bus.bus_init_error_n};
    s_nxt.ready = !s_r.rdy_s[1];
    s_nxt.req   = !s_r.br_s[1];
    s_nxt.seen  = !s_r.bi_s[1];
    s_nxt.fsel  = bus.clock_freq_select;
    // hold until one prio_done_i pulse with no request taken (a request wins while block next request reads high), however many priority requests came
    if (prio_want_i && s_r.bnr_s[1]) begin
      s_nxt.prio = 1'b1;
    end else if (prio_done_i) begin
      s_nxt.prio = 1'b0;
    end
    if (rst_i) begin
      s_nxt = '0;
    end
  end
  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end
  // error handling left to system logic through bus_init_error_seen_o
  assign bus.priority_bus_request_n = !s_r.prio;
  assign bus.cen_bus_init_error_oe           = bus_init_error_drive_i;
  assign bus.cen_bnr_oe             = stall_i;
  // probe request is not driven here; devices drive bit 5 high
  assign probe_ready_o = s_r.ready;
  assign agent_req_o   = s_r.req;
  assign bus_init_error_seen_o  = s_r.seen;
  assign freq_sel_o    = s_r.fsel;
  logic unused_probe_request;
  assign unused_probe_request = probe_req_i; // routed via device input
endmodule
`default_nettype wire

// file: fac_link_monitor.sv
`default_nettype none
module fac_link_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       bus_init_error_n,
  input wire logic       block_next_request_n,
  input wire logic       bus_request_zero_n,
  input wire logic [5:0] breakpoint_monitor_n,
  input wire logic [1:0] clock_freq_select,
  input wire logic       dev_bus_init_error_oe,
  input wire logic       dev_bnr_oe,
  input wire logic       cen_bus_init_error_oe,
  input wire logic       cen_bnr_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_req; $fell(rst_i) |-> bus_request_zero_n; endproperty
  a_rst_req: assert property (p_rst_req) else $error("request line not idle");
  property p_rst_bpm; $fell(rst_i) |-> breakpoint_monitor_n == 6'h3F; endproperty
  a_rst_bpm: assert property (p_rst_bpm) else $error("monitor group not idle");
  property p_rst_frq; $fell(rst_i) |-> clock_freq_select == 2'h1; endproperty
  a_rst_frq: assert property (p_rst_frq) else $error("freq select bad");
  property p_rst_oe; $fell(rst_i) |-> !dev_bus_init_error_oe && !dev_bnr_oe; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("device drives after reset");
  property p_bpm5; !$fell(rst_i) |-> breakpoint_monitor_n[5]; endproperty
  a_bpm5: assert property (p_bpm5) else $error("probe request bit driven low");
  // strap is taken once, so the select may not move after the first edge
  property p_frq; !$past(rst_i) && !$past(rst_i, 2) |-> $stable(clock_freq_select); endproperty
  a_frq: assert property (p_frq) else $error("freq select moved");
  property p_bus_init_error; dev_bus_init_error_oe || cen_bus_init_error_oe |-> !bus_init_error_n; endproperty
  a_bus_init_error: assert property (p_bus_init_error) else $error("bus init not low");
  property p_bnr; dev_bnr_oe || cen_bnr_oe |-> !block_next_request_n; endproperty
  a_bnr: assert property (p_bnr) else $error("stall not low");
endmodule
`default_nettype wire

// file: test_fsb_arbitration_control.sv
`default_nettype none
module test_fsb_arbitration_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, ps = 1, fe = 0, bz = 0, tr = 0, tl = 0, td = 0;
  logic pr = 0, pp = 1, pw = 0, pd = 0, st = 0, prq = 0, f;
  logic iss, prq_o, bsd, aid, opr, p_rdy, areq, bsc;
  logic [3:0] pend;
  logic [1:0] fsel;
  int bad_count = 0, n_tests = 0, cyc = 0;
  fac_bus_if bus ();
  always #2 clk_i = ~clk_i;
  fac_device_end fac_device_end_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .platform_select_i(ps), .bus_init_error_drive_en_i(1'b1), .bus_init_error_obs_en_i(1'b1),
    .fatal_err_i(fe), .busy_i(bz), .txn_req_i(tr), .txn_locked_i(tl), .txn_done_i(td),
    .probe_ready_i(pr), .bp_status_i(4'h5), .probe_req_pin_i(pp), .freq_sel_i(2'h2),
    .txn_issue_o(iss), .probe_req_o(prq_o), .bus_init_error_seen_o(bsd), .agent_id_o(aid),
    .pending_o(pend), .operational_o(opr));
  fac_central_end fac_central_end_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .prio_want_i(pw), .prio_done_i(pd), .bus_init_error_drive_i(1'b0), .stall_i(st),
    .probe_req_i(prq), .probe_ready_o(p_rdy), .agent_req_o(areq), .bus_init_error_seen_o(bsc),
    .freq_sel_o(fsel));
  fac_link_monitor fac_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
    .bus_init_error_n(bus.bus_init_error_n), .block_next_request_n(bus.block_next_request_n),
    .bus_request_zero_n(bus.bus_request_zero_n),
    .breakpoint_monitor_n(bus.breakpoint_monitor_n), .clock_freq_select(bus.clock_freq_select),
    .dev_bus_init_error_oe(bus.dev_bus_init_error_oe), .dev_bnr_oe(bus.dev_bnr_oe),
    .cen_bus_init_error_oe(bus.cen_bus_init_error_oe), .cen_bnr_oe(bus.cen_bnr_oe));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  // issue rises only once ownership is won, so it is latched over the window rather than sampled once
  task automatic wait_iss(input int n);
    f = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 if (iss === 1'b1) f = 1;
    end
    tick(1);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    tick(20);
    rst_i = 0;
    tick(8);
    chk(aid, 0);
    chk(opr, 1);
    chk(fsel, 2'h2);
    chk(bus.breakpoint_monitor_n[3:0], 4'hA);
    $display("test reset done");
    pulse(tr);
    wait_iss(10);
    chk(f, 1);
    pulse(td);
    st = 1;
    tick(1);
    chk(bus.block_next_request_n, 0);
    pulse(tr);
    wait_iss(12);
    chk(f, 0);
    st = 0;
    wait_iss(12);
    chk(f, 1);
    pulse(td);
    bz = 1;
    tick(2);
    chk(bus.block_next_request_n, 0);
    bz = 0;
    $display("test stall done");
    pw = 1;
    tick(5);
    chk(bus.priority_bus_request_n, 0);
    pulse(tr);
    wait_iss(12);
    chk(f, 0);
    tl = 1;
    wait_iss(12);
    chk(f, 1);
    tl = 0;
    pulse(td);
    pw = 0;
    pulse(pd);
    tick(4);
    chk(bus.priority_bus_request_n, 1);
    $display("test priority done");
    // entry is queued under stall first, since a halted device takes no new entries
    st = 1;
    pulse(tr);
    tick(4);
    ps = 0;
    tick(4);
    st = 0;
    chk(opr, 0);
    wait_iss(12);
    chk(f, 0);
    ps = 1;
    wait_iss(12);
    chk(f, 1);
    pulse(td);
    $display("test platform done");
    // priority held so the entry is still pending when bus init strikes
    pw = 1;
    pulse(tr);
    tick(2);
    fe = 1;
    tick(6);
    chk(bus.bus_init_error_n, 0);
    chk(bsc, 1);
    chk(bsd, 1);
    chk(pend, 4'h1);
    fe = 0;
    pw = 0;
    pulse(pd);
    wait_iss(20);
    chk(f, 1);
    pulse(td);
    $display("test bus init done");
    pp = 0;
    pr = 1;
    prq = 1;
    tick(6);
    chk(prq_o, 1);
    chk(p_rdy, 1);
    $display("test probe done");
    summarize();
  end
endmodule
`default_nettype wire
